// [inc/aba_pkg.sv]
// Purpose: Shared constants and types of the add and bit-logic execution block
// Assumes: 8-bit register space of 256 bytes, flag byte at its own index
// Notes:   Register indices are word indices on the bus; byte address is 4x

package aba_pkg;

   // ****************************************************************
   // Register space
   // ****************************************************************
   localparam logic [7:0] ABA_FLAGS_IDX = 8'hD5;
   localparam logic [7:0] ABA_WREG_BASE = 8'hC0;
   localparam logic [11:0] ABA_REGFILE_TOP = 12'h400;
   localparam logic [11:0] ABA_INSTR_ADDR = 12'h400;
   localparam logic [11:0] ABA_CTRL_ADDR = 12'h404;
   localparam logic [11:0] ABA_STATUS_ADDR = 12'h408;
   localparam logic [7:0] ABA_FLAGS_RESET = 8'h00;
   localparam logic [7:0] ABA_REG_RESET = 8'h00;

   // Flag bit positions
   localparam int ABA_FLAG_C = 7;
   localparam int ABA_FLAG_Z = 6;
   localparam int ABA_FLAG_S = 5;
   localparam int ABA_FLAG_V = 4;
   localparam int ABA_FLAG_D = 3;
   localparam int ABA_FLAG_H = 2;

   // Control and status bit positions
   localparam int ABA_CTRL_GO = 0;
   localparam int ABA_STAT_BUSY = 0;
   localparam int ABA_STAT_ERR = 1;

   // ****************************************************************
   // Opcodes and cycle counts
   // ****************************************************************
   localparam logic [7:0] ABA_OPC_ADD_RR = 8'h02;
   localparam logic [7:0] ABA_OPC_ADD_RIR = 8'h03;
   localparam logic [7:0] ABA_OPC_ADD_GG = 8'h04;
   localparam logic [7:0] ABA_OPC_ADD_GIR = 8'h05;
   localparam logic [7:0] ABA_OPC_ADD_GIM = 8'h06;
   localparam logic [7:0] ABA_OPC_AND_RR = 8'h52;
   localparam logic [7:0] ABA_OPC_AND_RIR = 8'h53;
   localparam logic [7:0] ABA_OPC_AND_GG = 8'h54;
   localparam logic [7:0] ABA_OPC_AND_GIR = 8'h55;
   localparam logic [7:0] ABA_OPC_AND_GIM = 8'h56;
   localparam logic [7:0] ABA_OPC_BAND = 8'h67;
   localparam logic [7:0] ABA_OPC_BCMP = 8'h17;
   localparam logic [2:0] ABA_CYC_SHORT = 3'h4;
   localparam logic [2:0] ABA_CYC_LONG = 3'h6;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {
      ABA_OP_ADD = 2'h0,
      ABA_OP_AND = 2'h1,
      ABA_OP_BAND = 2'h2,
      ABA_OP_BCMP = 2'h3
   } aba_op_t;

   typedef enum logic [2:0] {
      ABA_IDLE = 3'b001,
      ABA_EXEC = 3'b010,
      ABA_WAIT = 3'b100
   } aba_fsm_t;

endpackage : aba_pkg

// [inc/aba_alu_if.sv]
// Purpose: Carries operands, flags and results between sequencer and datapath
// Assumes: Purely combinational exchange within one clock
// Notes:   core modport drives operands, alu modport drives results

`timescale 1ns/100ps

interface aba_alu_if;
   import aba_pkg::*;
   aba_op_t op;
   logic [7:0] dst_val;
   logic [7:0] src_val;
   logic [2:0] bit_sel;
   logic form;
   logic [7:0] flags_in;
   logic [7:0] result;
   logic [7:0] flags_out;

   modport core (
      output op, dst_val, src_val, bit_sel, form, flags_in,
      input result, flags_out
   );
   modport alu (
      input op, dst_val, src_val, bit_sel, form, flags_in,
      output result, flags_out
   );
endinterface : aba_alu_if

// [rtl/aba_alu.sv]
// Purpose: Result and flag arithmetic for add, AND, bit-AND and bit compare
// Assumes: Operands already fetched by the sequencer
// Notes:   Undefined overflow after bit operations keeps its old value

`timescale 1ns/100ps

module aba_alu (
   // Operand and result exchange
   aba_alu_if.alu alu_if
);
   import aba_pkg::*;

   logic [8:0] sum;
   logic [4:0] low_sum;
   logic bit_res;

   always_comb begin
      sum = {1'b0, alu_if.dst_val} + {1'b0, alu_if.src_val};
      low_sum = {1'b0, alu_if.dst_val[3:0]} + {1'b0, alu_if.src_val[3:0]};
      bit_res = 1'b0;
      alu_if.result = alu_if.dst_val;
      alu_if.flags_out = alu_if.flags_in;
      case (alu_if.op)
         ABA_OP_ADD: begin
            alu_if.result = sum[7:0];
            alu_if.flags_out[ABA_FLAG_C] = sum[8];
            alu_if.flags_out[ABA_FLAG_Z] = (sum[7:0] == 8'h00);
            alu_if.flags_out[ABA_FLAG_S] = sum[7];
            alu_if.flags_out[ABA_FLAG_V] = (alu_if.dst_val[7] == alu_if.src_val[7])
               && (sum[7] != alu_if.dst_val[7]);
            alu_if.flags_out[ABA_FLAG_D] = 1'b0;
            alu_if.flags_out[ABA_FLAG_H] = low_sum[4];
         end
         ABA_OP_AND: begin
            alu_if.result = alu_if.dst_val & alu_if.src_val;
            alu_if.flags_out[ABA_FLAG_Z] = ((alu_if.dst_val & alu_if.src_val) == 8'h00);
            alu_if.flags_out[ABA_FLAG_S] = alu_if.dst_val[7] & alu_if.src_val[7];
            alu_if.flags_out[ABA_FLAG_V] = 1'b0;
         end
         ABA_OP_BAND: begin
            if (!alu_if.form) begin
               bit_res = alu_if.dst_val[0] & alu_if.src_val[alu_if.bit_sel];
               alu_if.result[0] = bit_res;
            end else begin
               bit_res = alu_if.dst_val[alu_if.bit_sel] & alu_if.src_val[0];
               alu_if.result[alu_if.bit_sel] = bit_res;
            end
            alu_if.flags_out[ABA_FLAG_Z] = !bit_res;
            alu_if.flags_out[ABA_FLAG_S] = 1'b0;
         end
         ABA_OP_BCMP: begin
            alu_if.flags_out[ABA_FLAG_Z] =
               (alu_if.dst_val[0] == alu_if.src_val[alu_if.bit_sel]);
            alu_if.flags_out[ABA_FLAG_S] = 1'b0;
         end
         default: begin
            alu_if.result = alu_if.dst_val;
         end
      endcase
   end

endmodule : aba_alu

// [rtl/aba_core.sv]
// Purpose: APB-reached execution block for add, AND, bit-AND and bit compare
// Assumes: Software loads an instruction word, then pulses go; one clock domain
// Notes:   The register space of 256 bytes, flags included, is bus visible
//
// Behaviour
// - Add sums operands, writes destination only
// - Add carry reflects carry out of bit 7
// - Add zero and sign follow the result
// - Add overflow on same-sign operands, flipped result
// - Add clears decimal flag, half carry from nibble
// - AND stores bitwise AND, opcodes 52..56
// - AND sets zero, sign; clears overflow only
// - Bit-AND combines selected bit with bit zero
// - Bit-AND touches one bit; zero set, sign cleared
// - Bit compare 17 writes nothing back
// - Bit compare zero when bits equal, sign cleared
// - Bit compare six cycles, second-byte LSB zero
//
// Added by the designer: the APB interface to the registers.

`timescale 1ns/100ps

module aba_core (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Execution status
   output logic busy_out,
   output logic done_out
);
   import aba_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [255:0][7:0] regs;
      logic [7:0] flags;
      logic [7:0] opc;
      logic [7:0] byte2;
      logic [7:0] byte3;
      aba_fsm_t state;
      logic [2:0] cnt;
      logic err;
      logic busy;
      logic done;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } aba_st_t;

   aba_st_t st_ff;
   aba_st_t nxt_st;

   aba_alu_if alu_if ();

   aba_alu u_alu (
      .alu_if(alu_if.alu)
   );

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [7:0] aba_wreg(input logic [3:0] num);
      aba_wreg = ABA_WREG_BASE | {4'h0, num};
   endfunction : aba_wreg

   // The flag byte lives outside the array but answers at its own index
   function automatic logic [7:0] aba_rd(input aba_st_t s, input logic [7:0] addr);
      if (addr == ABA_FLAGS_IDX) begin
         aba_rd = s.flags;
      end else begin
         aba_rd = s.regs[addr];
      end
   endfunction : aba_rd

   function automatic logic aba_legal(input logic [7:0] opc, input logic [7:0] b2);
      case (opc)
         ABA_OPC_ADD_RR, ABA_OPC_ADD_RIR, ABA_OPC_ADD_GG, ABA_OPC_ADD_GIR,
         ABA_OPC_ADD_GIM, ABA_OPC_AND_RR, ABA_OPC_AND_RIR, ABA_OPC_AND_GG,
         ABA_OPC_AND_GIR, ABA_OPC_AND_GIM, ABA_OPC_BAND: begin
            aba_legal = 1'b1;
         end
         ABA_OPC_BCMP: begin
            aba_legal = !b2[0];
         end
         default: begin
            aba_legal = 1'b0;
         end
      endcase
   endfunction : aba_legal

   function automatic logic [2:0] aba_cycles(input logic [7:0] opc);
      if (opc == ABA_OPC_ADD_RR || opc == ABA_OPC_AND_RR) begin
         aba_cycles = ABA_CYC_SHORT;
      end else begin
         aba_cycles = ABA_CYC_LONG;
      end
   endfunction : aba_cycles

   // ****************************************************************
   // Operand decode
   // ****************************************************************
   logic [7:0] dst_addr;
   logic [7:0] src_val;
   logic dst_val_sel;
   logic wb_en;
   aba_op_t op;

   always_comb begin
      dst_addr = aba_wreg(st_ff.byte2[7:4]);
      src_val = aba_rd(st_ff, aba_wreg(st_ff.byte2[3:0]));
      dst_val_sel = 1'b0;
      wb_en = 1'b1;
      op = (st_ff.opc[7:4] == 4'h5) ? ABA_OP_AND : ABA_OP_ADD;
      case (st_ff.opc)
         ABA_OPC_ADD_RR, ABA_OPC_AND_RR: begin
            dst_addr = aba_wreg(st_ff.byte2[7:4]);
            src_val = aba_rd(st_ff, aba_wreg(st_ff.byte2[3:0]));
         end
         ABA_OPC_ADD_RIR, ABA_OPC_AND_RIR: begin
            dst_addr = aba_wreg(st_ff.byte2[7:4]);
            src_val = aba_rd(st_ff, aba_rd(st_ff, aba_wreg(st_ff.byte2[3:0])));
         end
         ABA_OPC_ADD_GG, ABA_OPC_AND_GG: begin
            dst_addr = st_ff.byte3;
            src_val = aba_rd(st_ff, st_ff.byte2);
         end
         ABA_OPC_ADD_GIR, ABA_OPC_AND_GIR: begin
            dst_addr = st_ff.byte3;
            src_val = aba_rd(st_ff, aba_rd(st_ff, st_ff.byte2));
         end
         ABA_OPC_ADD_GIM, ABA_OPC_AND_GIM: begin
            dst_addr = st_ff.byte2;
            src_val = st_ff.byte3;
         end
         ABA_OPC_BAND: begin
            op = ABA_OP_BAND;
            if (!st_ff.byte2[0]) begin
               dst_addr = aba_wreg(st_ff.byte2[7:4]);
               src_val = aba_rd(st_ff, st_ff.byte3);
            end else begin
               dst_addr = st_ff.byte3;
               src_val = aba_rd(st_ff, aba_wreg(st_ff.byte2[7:4]));
            end
         end
         ABA_OPC_BCMP: begin
            op = ABA_OP_BCMP;
            dst_addr = aba_wreg(st_ff.byte2[7:4]);
            src_val = aba_rd(st_ff, st_ff.byte3);
            wb_en = 1'b0;
         end
         default: begin
            wb_en = 1'b0;
            dst_val_sel = 1'b1;
         end
      endcase
   end

   // Operands to the datapath
   always_comb begin
      alu_if.op = op;
      alu_if.dst_val = dst_val_sel ? 8'h00 : aba_rd(st_ff, dst_addr);
      alu_if.src_val = src_val;
      alu_if.bit_sel = st_ff.byte2[3:1];
      alu_if.form = st_ff.byte2[0];
      alu_if.flags_in = st_ff.flags;
   end

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   logic bus_setup;
   logic bus_commit;
   logic in_regfile;
   logic mapped;
   logic [7:0] bus_idx;

   always_comb begin
      bus_setup = psel_in && penable_in && !st_ff.pready;
      bus_commit = psel_in && penable_in && st_ff.pready;
      bus_idx = paddr_in[9:2];
      in_regfile = paddr_in < ABA_REGFILE_TOP;
      mapped = (paddr_in[1:0] == 2'h0) && (in_regfile
         || paddr_in == ABA_INSTR_ADDR || paddr_in == ABA_CTRL_ADDR
         || paddr_in == ABA_STATUS_ADDR);
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      nxt_st = st_ff;
      nxt_st.done = 1'b0;
      nxt_st.pready = 1'b0;
      nxt_st.pslverr = 1'b0;

      // One wait state: data is prepared on the first access cycle
      if (bus_setup) begin
         nxt_st.pready = 1'b1;
         nxt_st.pslverr = !mapped;
         nxt_st.prdata = 32'h0000_0000;
         if (mapped && !pwrite_in) begin
            if (in_regfile) begin
               nxt_st.prdata = {24'h00_0000, aba_rd(st_ff, bus_idx)};
            end else if (paddr_in == ABA_INSTR_ADDR) begin
               nxt_st.prdata = {8'h00, st_ff.byte3, st_ff.byte2, st_ff.opc};
            end else if (paddr_in == ABA_STATUS_ADDR) begin
               nxt_st.prdata[ABA_STAT_BUSY] = st_ff.busy;
               nxt_st.prdata[ABA_STAT_ERR] = st_ff.err;
            end
         end
      end

      // Writes take effect at the completing edge; ignored while busy
      if (bus_commit && pwrite_in && mapped && !st_ff.busy) begin
         if (in_regfile) begin
            if (bus_idx == ABA_FLAGS_IDX) begin
               nxt_st.flags = pwdata_in[7:0];
            end else begin
               nxt_st.regs[bus_idx] = pwdata_in[7:0];
            end
         end else if (paddr_in == ABA_INSTR_ADDR) begin
            nxt_st.opc = pwdata_in[7:0];
            nxt_st.byte2 = pwdata_in[15:8];
            nxt_st.byte3 = pwdata_in[23:16];
         end else if (paddr_in == ABA_CTRL_ADDR && pwdata_in[ABA_CTRL_GO]) begin
            if (aba_legal(st_ff.opc, st_ff.byte2)) begin
               nxt_st.err = 1'b0;
               nxt_st.busy = 1'b1;
               nxt_st.state = ABA_EXEC;
            end else begin
               nxt_st.err = 1'b1;
            end
         end
      end

      case (st_ff.state)
         ABA_IDLE: begin
            nxt_st.cnt = 3'h0;
         end
         ABA_EXEC: begin
            // Flag update overrides a result aimed at the flag byte
            if (wb_en) begin
               if (dst_addr == ABA_FLAGS_IDX) begin
                  nxt_st.flags = alu_if.result;
               end else begin
                  nxt_st.regs[dst_addr] = alu_if.result;
               end
            end
            nxt_st.flags = alu_if.flags_out;
            nxt_st.cnt = aba_cycles(st_ff.opc) - 3'h2;
            nxt_st.state = ABA_WAIT;
         end
         ABA_WAIT: begin
            if (st_ff.cnt == 3'h0) begin
               nxt_st.state = ABA_IDLE;
               nxt_st.busy = 1'b0;
               nxt_st.done = 1'b1;
            end else begin
               nxt_st.cnt = st_ff.cnt - 3'h1;
            end
         end
         default: begin
            nxt_st.state = ABA_IDLE;
            nxt_st.busy = 1'b0;
         end
      endcase
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         st_ff.regs <= {256{ABA_REG_RESET}};
         st_ff.flags <= ABA_FLAGS_RESET;
         st_ff.opc <= 8'h00;
         st_ff.byte2 <= 8'h00;
         st_ff.byte3 <= 8'h00;
         st_ff.state <= ABA_IDLE;
         st_ff.cnt <= 3'h0;
         st_ff.err <= 1'b0;
         st_ff.busy <= 1'b0;
         st_ff.done <= 1'b0;
         st_ff.prdata <= 32'h0000_0000;
         st_ff.pready <= 1'b0;
         st_ff.pslverr <= 1'b0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign prdata_out = st_ff.prdata;
   assign pready_out = st_ff.pready;
   assign pslverr_out = st_ff.pslverr;
   assign busy_out = st_ff.busy;
   assign done_out = st_ff.done;

endmodule : aba_core

// [bench/aba_core_sva.sv]
// Purpose: Port-level checks of the execution block's bus and run timing
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Legality of an opcode is recomputed here from the last instruction word the block accepted

`timescale 1ns/100ps

module aba_core_sva
   import aba_pkg::*;
(
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   // Execution status
   input wire logic busy_out,
   input wire logic done_out
);
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (rst_in);

   // ****************************************
   // Helper logic
   // ****************************************
   // Last instruction word the block accepted; an illegal one must never start a run
   logic [15:0] instr_ff;
   logic go_legal;

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         instr_ff <= 16'h0000;
      end else if (pready_out && pwrite_in && paddr_in == ABA_INSTR_ADDR && !busy_out) begin
         instr_ff <= pwdata_in[15:0];
      end
   end

   always_comb begin
      case (instr_ff[7:0])
         ABA_OPC_ADD_RR, ABA_OPC_ADD_RIR, ABA_OPC_ADD_GG, ABA_OPC_ADD_GIR,
         ABA_OPC_ADD_GIM, ABA_OPC_AND_RR, ABA_OPC_AND_RIR, ABA_OPC_AND_GG,
         ABA_OPC_AND_GIR, ABA_OPC_AND_GIM, ABA_OPC_BAND: begin
            go_legal = 1'b1;
         end
         ABA_OPC_BCMP: begin
            go_legal = !instr_ff[8];
         end
         default: begin
            go_legal = 1'b0;
         end
      endcase
   end

   // ****************************************
   // Sequences
   // ****************************************
   sequence s_short;
      busy_out[*4] ##1 (!busy_out && done_out);
   endsequence
   sequence s_long;
      busy_out[*6] ##1 (!busy_out && done_out);
   endsequence
   sequence s_go;
      pready_out && pwrite_in && paddr_in == ABA_CTRL_ADDR && pwdata_in[ABA_CTRL_GO]
         && !busy_out;
   endsequence

   // ****************************************
   // Properties
   // ****************************************
   property p_ready_after_access;
      psel_in && $rose(penable_in) |=> pready_out;
   endproperty
   property p_ready_pulse;
      pready_out |=> !pready_out;
   endproperty
   property p_err_with_ready;
      pslverr_out |-> pready_out && prdata_out == 32'h0;
   endproperty
   property p_ready_in_access;
      pready_out |-> psel_in && penable_in;
   endproperty
   property p_busy_span;
      $rose(busy_out) |-> s_short or s_long;
   endproperty
   property p_go_starts;
      $rose(busy_out) |-> $past(pready_out && pwrite_in && paddr_in == ABA_CTRL_ADDR);
   endproperty
   property p_go_runs;
      s_go ##0 go_legal |=> busy_out;
   endproperty
   property p_bad_go_idle;
      s_go ##0 !go_legal |=> !busy_out;
   endproperty
   property p_done_ends;
      done_out |-> $fell(busy_out);
   endproperty
   property p_done_pulse;
      done_out |=> !done_out && !busy_out;
   endproperty

   a_ready_after_access: assert property (p_ready_after_access)
      else $error("pready late after access");
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("pready longer than one cycle");
   a_err_with_ready: assert property (p_err_with_ready)
      else $error("pslverr without pready or with data");
   a_ready_in_access: assert property (p_ready_in_access)
      else $error("pready outside access");
   a_busy_span: assert property (p_busy_span)
      else $error("run length wrong");
   a_go_starts: assert property (p_go_starts)
      else $error("run without go write");
   a_go_runs: assert property (p_go_runs)
      else $error("go write ignored");
   a_bad_go_idle: assert property (p_bad_go_idle)
      else $error("illegal instruction started a run");
   a_done_ends: assert property (p_done_ends)
      else $error("done not at end of busy");
   a_done_pulse: assert property (p_done_pulse)
      else $error("done longer than one cycle");
endmodule : aba_core_sva

bind aba_core aba_core_sva u_aba_core_sva (
   .clock_in(clock_in),
   .rst_in(rst_in),
   .psel_in(psel_in),
   .penable_in(penable_in),
   .pwrite_in(pwrite_in),
   .paddr_in(paddr_in),
   .pwdata_in(pwdata_in),
   .prdata_out(prdata_out),
   .pready_out(pready_out),
   .pslverr_out(pslverr_out),
   .busy_out(busy_out),
   .done_out(done_out)
);

// [bench/tb.sv]
// Purpose: Self-checking bench running each instruction through the APB
// Assumes: 100 MHz clock, reset held 12 cycles
// Notes:   Each case presets five registers and flags, runs, reads all back

`timescale 1ns/100ps

module tb;
   import aba_pkg::*;

   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic busy;
   logic done;
   logic [31:0] rd;
   logic er;
   int miscompares = 0;
   int checks_done = 0;
   // Working regs 1 and 2, then registers 01..03
   logic [11:0] addrs [5] = '{12'h304, 12'h308, 12'h004, 12'h008, 12'h00C};
   localparam logic [11:0] FLAGS_A = 12'h354;
   // Bit compare with form bit set, then an opcode the block does not know
   logic [15:0] bad [2] = '{16'h1317, 16'h00FF};

   aba_core u_aba_core (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .psel_in(psel),
      .penable_in(penable),
      .pwrite_in(pwrite),
      .paddr_in(paddr),
      .pwdata_in(pwdata),
      .prdata_out(prdata),
      .pready_out(pready),
      .pslverr_out(pslverr),
      .busy_out(busy),
      .done_out(done)
   );

   initial begin
      forever #5 clock_in = ~clock_in;
   end

   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // Called just after an edge; one idle edge at the end avoids re-driving
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_in);
      penable <= 1'b1;
      do begin
         @(posedge clock_in);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock_in);
      if (n >= 20) chk("pready", 32'h0, 32'h1);
   endtask : apb

   task automatic tc(input logic [7:0] op, b2, b3, input logic [39:0] pre,
                     input logic [7:0] fp, input logic [39:0] post, input logic [7:0] fx);
      int n;
      n = 0;
      for (int i = 0; i < 5; i++) apb(1'b1, addrs[i], {24'h0, pre[39-8*i -: 8]});
      apb(1'b1, FLAGS_A, {24'h0, fp});
      apb(1'b1, ABA_INSTR_ADDR, {8'h00, b3, b2, op});
      apb(1'b1, ABA_CTRL_ADDR, 32'h1);
      do begin
         @(posedge clock_in);
         n++;
      end while (done !== 1'b1 && n < 20);
      chk("cycles", n, (op == ABA_OPC_ADD_RR || op == ABA_OPC_AND_RR) ? 4 : 6);
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, addrs[i], 32'h0);
         chk($sformatf("reg%0d", i), rd, {24'h0, post[39-8*i -: 8]});
      end
      apb(1'b0, FLAGS_A, 32'h0);
      chk("flags", rd, {24'h0, fx});
      apb(1'b0, ABA_STATUS_ADDR, 32'h0);
      chk("status", rd, 32'h0);
   endtask : tc

   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test

   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      #200000;
      miscompares++;
      finish_test();
   end

   initial begin
      repeat (12) @(posedge clock_in);
      rst_in <= 1'b0;
      @(posedge clock_in);
      apb(1'b0, FLAGS_A, 32'h0);
      chk("flags rst", rd, 32'h0);
      apb(1'b0, ABA_CTRL_ADDR, 32'h0);
      chk("ctrl rd", rd, 32'h0);
      apb(1'b0, 12'h40C, 32'h0);
      chk("unmapped", {er, rd[30:0]}, 32'h8000_0000);
      apb(1'b1, 12'h355, 32'hFF);
      chk("misalign", er, 32'h1);
      tc(8'h02, 8'h12, 8'h00, 40'h8F81112233, 8'h6B, 40'h1081112233, 8'h97);
      tc(8'h03, 8'h12, 8'h00, 40'hF60311220A, 8'h00, 40'h000311220A, 8'hC4);
      tc(8'h04, 8'h02, 8'h01, 40'h1122701033, 8'h80, 40'h1122801033, 8'h30);
      tc(8'h05, 8'h02, 8'h01, 40'h11222F030A, 8'h00, 40'h112239030A, 8'h04);
      tc(8'h06, 8'h01, 8'h25, 40'h1122214455, 8'hFF, 40'h1122464455, 8'h03);
      tc(8'h52, 8'h12, 8'h00, 40'h1203112233, 8'hFF, 40'h0203112233, 8'h8F);
      tc(8'h53, 8'h12, 8'h00, 40'h120311220A, 8'h10, 40'h020311220A, 8'h00);
      tc(8'h54, 8'h02, 8'h01, 40'h1122210233, 8'h00, 40'h1122000233, 8'h40);
      tc(8'h55, 8'h02, 8'h01, 40'h1122A1038A, 8'h00, 40'h112280038A, 8'h20);
      tc(8'h56, 8'h01, 8'h25, 40'h1122214455, 8'h84, 40'h1122214455, 8'h84);
      tc(8'h67, 8'h12, 8'h01, 40'h0722054455, 8'hAF, 40'h0622054455, 8'hCF);
      tc(8'h67, 8'h15, 8'h01, 40'h0622054455, 8'h00, 40'h0622014455, 8'h40);
      tc(8'h17, 8'h12, 8'h01, 40'h0722014455, 8'hFF, 40'h0722014455, 8'h9F);
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, ABA_INSTR_ADDR, {16'h0100, bad[i]});
         apb(1'b1, ABA_CTRL_ADDR, 32'h1);
         repeat (8) @(posedge clock_in);
         apb(1'b0, ABA_STATUS_ADDR, 32'h0);
         chk("illegal", rd, 32'h2);
      end
      tc(8'h17, 8'h10, 8'h01, 40'h0722014455, 8'h00, 40'h0722014455, 8'h40);
      finish_test();
   end
endmodule : tb
